// [hdl/vr_sequencer_serial_vid_slave.sv]
// Two-rail sequencer, power-good, protection latches and serial command slave
`timescale 1ns/1ps
module vr_sequencer_serial_vid_slave #(
	parameter int READY_CYCLES = vr_seq_pkg::READY_CYCLES,
	parameter int TELEM_BITS = vr_seq_pkg::TELEM_BITS
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Supply and enable comparators
	input wire logic mainSupplyOk,
	input wire logic driverSupplyOk,
	input wire logic enableHigh,
	// Platform and serial pins
	input wire logic platformPowerOk,
	input wire logic serialVidClock,
	input wire logic serialVidData,
	// Per-rail analog status, bit 0 core, bit 1 northbridge
	input wire logic [1:0] inRegulation,
	input wire logic [1:0] aboveOffLevel,
	input wire logic [1:0] overVoltageTrip,
	input wire logic [1:0] overCurrentTrip,
	input wire logic [1:0] underVoltageTrip,
	// Telemetry sample from the converter
	input wire logic [TELEM_BITS-1:0] telemetryWord,
	// Sequencer status
	output logic powerReady,
	output logic serialReady,
	output logic sequenceFault,
	output logic [1:0] startupVoltageCode,
	// Serial link output
	output logic telemetryLine,
	output logic [2:0] telemetryFunction,
	// Per-rail outputs
	output logic [1:0] powerGood,
	output logic [1:0] switchingOn,
	output logic [1:0] diodeEmulation,
	output logic [1:0] tripLatched,
	output logic [1:0] transitionDone,
	output logic [7:0] coreReference,
	output logic [7:0] nbReference
);
	localparam int RW = $clog2(READY_CYCLES + 1);
	localparam int PW = $clog2(vr_seq_pkg::PG_DELAY_CYCLES + 1);
	localparam int CW = $clog2(vr_seq_pkg::CROSS_TRIP_CYCLES + 1);
	localparam int SW = $clog2(vr_seq_pkg::SS_STEP_CYCLES + 1);
	localparam int VW = $clog2(vr_seq_pkg::VID_STEP_CYCLES + 1);
	localparam int NB = vr_seq_pkg::PKT_BITS;

	logic [15:0] rawIn;
	logic [15:0] syncA;
	logic [15:0] syncB;
	logic mainOk, drvOk, en, pok, sclk, sdat;
	logic enPrev, pokPrev, sclkPrev, sdatPrev;
	logic enRise, pokRise, sclkRise, sclkFall;
	logic bootValid;
	logic [7:0] bootLevel;
	vr_seq_pkg::seq_state_t stateReg, stateNext;
	logic [PW-1:0] pgCnt;
	logic [RW-1:0] readyCnt;
	logic [SW-1:0] ssCnt;
	logic [VW-1:0] vidCnt;
	logic ssTick, vidTick;
	logic pokAfterEn, serialRun, serialRunPrev, runFall;
	logic inFrame;
	logic [4:0] bitCnt;
	logic [NB-1:0] shiftReg;
	logic startCond, stopCond, cmdValid;
	logic [1:0] selVec;
	logic [7:0] vidCode, vidLevel;
	logic [TELEM_BITS-1:0] telemShift;
	logic [7:0] target [2];
	logic [7:0] refLevel [2];
	logic [1:0] atTarget;
	logic [1:0] transitioning;
	logic [1:0] psi0;
	logic [1:0] crossHit;
	logic seqActive;

	// Two-flop synchronisers for every outside input except reset and the telemetry word
	assign rawIn = {underVoltageTrip, overCurrentTrip, overVoltageTrip, aboveOffLevel,
		inRegulation, serialVidData, serialVidClock, platformPowerOk, enableHigh,
		driverSupplyOk, mainSupplyOk};
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			syncA <= 16'h0000;
			syncB <= 16'h0000;
		end
		else
		begin
			syncA <= rawIn;
			syncB <= syncA;
		end
	end
	assign mainOk = syncB[0];
	assign drvOk = syncB[1];
	assign en = syncB[2];
	assign pok = syncB[3];
	assign sclk = syncB[4];
	assign sdat = syncB[5];

	// Previous samples for edge finding
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			enPrev <= 1'b0;
			pokPrev <= 1'b0;
			sclkPrev <= 1'b0;
			sdatPrev <= 1'b0;
			serialRunPrev <= 1'b0;
		end
		else
		begin
			enPrev <= en;
			pokPrev <= pok;
			sclkPrev <= sclk;
			sdatPrev <= sdat;
			serialRunPrev <= serialRun;
		end
	end
	assign enRise = en & ~enPrev;
	assign pokRise = pok & ~pokPrev;
	assign sclkRise = sclk & ~sclkPrev;
	assign sclkFall = ~sclk & sclkPrev;
	assign runFall = serialRunPrev & ~serialRun;

	// Power-ready from both supply comparators
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			powerReady <= 1'b0;
		else
			powerReady <= mainOk & drvOk;
	end

	// Start-up code capture, once per power-ready period
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			bootValid <= 1'b0;
			startupVoltageCode <= 2'h0;
		end
		else if (!powerReady)
		begin
			bootValid <= 1'b0;
			startupVoltageCode <= 2'h0;
		end
		else if (enRise && !bootValid)
		begin
			bootValid <= 1'b1;
			startupVoltageCode <= {sclk, sdat};
		end
	end

	// Start-up code to reference level
	always_comb
	begin
		case (startupVoltageCode)
			2'h0: bootLevel = vr_seq_pkg::BOOT_LEVEL_00;
			2'h1: bootLevel = vr_seq_pkg::BOOT_LEVEL_01;
			2'h2: bootLevel = vr_seq_pkg::BOOT_LEVEL_10;
			default: bootLevel = vr_seq_pkg::BOOT_LEVEL_11;
		endcase
	end

	// Enable seen while power-ok already high blocks the start
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			sequenceFault <= 1'b0;
		else if (!en)
			sequenceFault <= 1'b0;
		else if (enRise && pok)
			sequenceFault <= 1'b1;
	end

	// Sequencer next state
	always_comb
	begin
		stateNext = stateReg;
		case (stateReg)
			vr_seq_pkg::ST_OFF:
				if (powerReady && en && bootValid && !sequenceFault)
					stateNext = vr_seq_pkg::ST_SOFTSTART;
			vr_seq_pkg::ST_SOFTSTART:
				if (refLevel[0] == bootLevel && refLevel[1] == bootLevel)
					stateNext = vr_seq_pkg::ST_PGWAIT;
			vr_seq_pkg::ST_PGWAIT:
				if (pgCnt == PW'(vr_seq_pkg::PG_DELAY_CYCLES - 1))
					stateNext = vr_seq_pkg::ST_RUN;
			vr_seq_pkg::ST_RUN:
				stateNext = vr_seq_pkg::ST_RUN;
			vr_seq_pkg::ST_SHUTDOWN:
				if (switchingOn == 2'h0 && refLevel[0] == vr_seq_pkg::LEVEL_RESET
					&& refLevel[1] == vr_seq_pkg::LEVEL_RESET)
					stateNext = vr_seq_pkg::ST_OFF;
			default:
				stateNext = vr_seq_pkg::ST_OFF;
		endcase
		if (!powerReady)
			stateNext = vr_seq_pkg::ST_OFF;
		else if (!en && stateReg != vr_seq_pkg::ST_OFF)
			stateNext = vr_seq_pkg::ST_SHUTDOWN;
	end

	// Sequencer state register
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			stateReg <= vr_seq_pkg::ST_OFF;
		else
			stateReg <= stateNext;
	end
	assign seqActive = (stateReg == vr_seq_pkg::ST_PGWAIT) || (stateReg == vr_seq_pkg::ST_RUN);

	// Power-good delay, restarts when any output leaves regulation
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			pgCnt <= '0;
		else if (stateReg != vr_seq_pkg::ST_PGWAIT || syncB[7:6] != 2'h3)
			pgCnt <= '0;
		else
			pgCnt <= pgCnt + PW'(1);
	end

	// Interface readiness timer from enable
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			readyCnt <= '0;
			serialReady <= 1'b0;
		end
		else if (stateReg == vr_seq_pkg::ST_OFF || stateReg == vr_seq_pkg::ST_SHUTDOWN)
		begin
			readyCnt <= '0;
			serialReady <= 1'b0;
		end
		else
		begin
			if (readyCnt != RW'(READY_CYCLES - 1))
				readyCnt <= readyCnt + RW'(1);
			serialReady <= seqActive || (readyCnt == RW'(READY_CYCLES - 1));
		end
	end

	// Slew dividers: soft-start and voltage transition steps
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			ssCnt <= '0;
			vidCnt <= '0;
		end
		else
		begin
			ssCnt <= ssTick ? '0 : ssCnt + SW'(1);
			vidCnt <= vidTick ? '0 : vidCnt + VW'(1);
		end
	end
	assign ssTick = (ssCnt == SW'(vr_seq_pkg::SS_STEP_CYCLES - 1));
	assign vidTick = (vidCnt == VW'(vr_seq_pkg::VID_STEP_CYCLES - 1));

	// Interface run gate: power-ok must rise after enable
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			pokAfterEn <= 1'b0;
			serialRun <= 1'b0;
		end
		else
		begin
			if (!en)
				pokAfterEn <= 1'b0;
			else if (pokRise)
				pokAfterEn <= 1'b1;
			serialRun <= en && pok && pokAfterEn && serialReady && !sequenceFault;
		end
	end

	// Start and stop conditions while clock is high
	assign startCond = serialRun & sclk & sclkPrev & sdatPrev & ~sdat;
	assign stopCond = serialRun & sclk & sclkPrev & ~sdatPrev & sdat;

	// Packet receiver, bits taken on clock rising edges
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			inFrame <= 1'b0;
			bitCnt <= 5'h00;
			shiftReg <= '0;
		end
		else if (!serialRun)
		begin
			inFrame <= 1'b0;
			bitCnt <= 5'h00;
		end
		else if (startCond)
		begin
			inFrame <= 1'b1;
			bitCnt <= 5'h00;
			shiftReg <= '0;
		end
		else if (stopCond)
			inFrame <= 1'b0;
		else if (inFrame && sclkRise && bitCnt != 5'h1F)
		begin
			if (bitCnt < 5'(NB))
				shiftReg <= {shiftReg[NB-2:0], sdat};
			bitCnt <= bitCnt + 5'h01; // Stop's own clock rise counts as NB + 1
		end
	end

	// Field decode, acted on only at the stop condition
	assign cmdValid = stopCond && inFrame && bitCnt == 5'(NB + 1)
		&& shiftReg[NB-vr_seq_pkg::BT_PATTERN_HI -: 5] == vr_seq_pkg::PKT_PATTERN
		&& !shiftReg[NB-vr_seq_pkg::BT_ZERO];
	assign selVec = {shiftReg[NB-vr_seq_pkg::BT_SEL_NB], shiftReg[NB-vr_seq_pkg::BT_SEL_CORE]};
	assign vidCode = {shiftReg[NB-vr_seq_pkg::BT_VID_HI -: 7], shiftReg[NB-vr_seq_pkg::BT_VID0]};
	assign vidLevel = (vidCode >= vr_seq_pkg::VID_TOP_LEVEL) ? vr_seq_pkg::LEVEL_RESET
		: vr_seq_pkg::VID_TOP_LEVEL - vidCode;

	// Telemetry function selection
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			telemetryFunction <= 3'h0;
		else if (cmdValid)
			telemetryFunction <= {shiftReg[NB-vr_seq_pkg::BT_TFN], selVec};
	end

	// Telemetry shifter, advanced on serial clock falling edges
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			telemShift <= '1;
			telemetryLine <= 1'b0;
		end
		else
		begin
			if (startCond)
				telemShift <= telemetryWord;
			else if (inFrame && sclkFall && bitCnt != 5'h00)
				telemShift <= {telemShift[TELEM_BITS-2:0], 1'b1};
			if (!bootValid)
				telemetryLine <= 1'b0;
			else if (serialRun && inFrame)
				telemetryLine <= telemShift[TELEM_BITS-1];
			else
				telemetryLine <= 1'b1;
		end
	end

	assign coreReference = refLevel[0];
	assign nbReference = refLevel[1];

	// Per-rail reference, mode, switching, trip and power-good logic
	for (genvar i = 0; i < 2; i++)
	begin : g_rail
		logic setMove;
		logic [CW-1:0] crossCnt;

		assign setMove = seqActive && (runFall || (cmdValid && selVec[i]));

		ref_ramp #(
			.W(vr_seq_pkg::LEVEL_W)
		) u_ramp (
			.core_clk(core_clk),
			.reset(reset),
			.stepEn(transitioning[i] ? vidTick : ssTick),
			.target(target[i]),
			.level(refLevel[i]),
			.atTarget(atTarget[i])
		);

		// Reference target selection
		always_ff @(posedge core_clk or posedge reset)
		begin
			if (reset)
				target[i] <= vr_seq_pkg::LEVEL_RESET;
			else if (stateReg == vr_seq_pkg::ST_OFF || stateReg == vr_seq_pkg::ST_SHUTDOWN)
				target[i] <= vr_seq_pkg::LEVEL_RESET;
			else if (stateReg == vr_seq_pkg::ST_SOFTSTART)
				target[i] <= bootLevel;
			else if (runFall)
				target[i] <= bootLevel;
			else if (cmdValid && selVec[i])
				target[i] <= vidLevel;
		end

		// Transition tracking and completion pulse
		always_ff @(posedge core_clk or posedge reset)
		begin
			if (reset)
			begin
				transitioning[i] <= 1'b0;
				transitionDone[i] <= 1'b0;
			end
			else
			begin
				transitionDone[i] <= seqActive && transitioning[i] && atTarget[i]
					&& !setMove;
				if (setMove)
					transitioning[i] <= 1'b1;
				else if (!seqActive || atTarget[i])
					transitioning[i] <= 1'b0;
			end
		end

		// Power-state flag and conduction mode
		always_ff @(posedge core_clk or posedge reset)
		begin
			if (reset)
			begin
				psi0[i] <= 1'b1;
				diodeEmulation[i] <= 1'b0;
			end
			else
			begin
				if (!seqActive || runFall)
					psi0[i] <= 1'b1;
				else if (cmdValid && selVec[i])
					psi0[i] <= shiftReg[NB-vr_seq_pkg::BT_PSI0];
				diodeEmulation[i] <= (stateReg == vr_seq_pkg::ST_RUN) && !psi0[i]
					&& !transitioning[i];
			end
		end

		// Switching stops as sensed output falls through the off level
		always_ff @(posedge core_clk or posedge reset)
		begin
			if (reset)
				switchingOn[i] <= 1'b0;
			else if (stateReg == vr_seq_pkg::ST_OFF)
				switchingOn[i] <= 1'b0;
			else if (stateReg == vr_seq_pkg::ST_SOFTSTART)
				switchingOn[i] <= 1'b1;
			else if (stateReg == vr_seq_pkg::ST_SHUTDOWN && !syncB[8+i])
				switchingOn[i] <= 1'b0;
		end

		// Protection latch, cleared only by power-ready loss
		always_ff @(posedge core_clk or posedge reset)
		begin
			if (reset)
				tripLatched[i] <= 1'b0;
			else if (!powerReady)
				tripLatched[i] <= 1'b0;
			else if (syncB[10+i] || syncB[12+i] || syncB[14+i])
				tripLatched[i] <= 1'b1;
		end

		// Delay before the other rail's trip pulls this rail down
		always_ff @(posedge core_clk or posedge reset)
		begin
			if (reset)
			begin
				crossCnt <= '0;
				crossHit[i] <= 1'b0;
			end
			else if (!tripLatched[1-i])
			begin
				crossCnt <= '0;
				crossHit[i] <= 1'b0;
			end
			else if (crossCnt != CW'(vr_seq_pkg::CROSS_TRIP_CYCLES - 1))
				crossCnt <= crossCnt + CW'(1);
			else
				crossHit[i] <= 1'b1;
		end

		// Power-good: released per rail in run, pulled by trips and enable loss
		always_ff @(posedge core_clk or posedge reset)
		begin
			if (reset)
				powerGood[i] <= 1'b0;
			else
				powerGood[i] <= (stateReg == vr_seq_pkg::ST_RUN) && en && mainOk && drvOk
					&& !tripLatched[i] && !crossHit[i]
					&& (powerGood[i] || syncB[6+i]);
		end
	end
endmodule // vr_sequencer_serial_vid_slave

// [hdl/vr_seq_pkg.sv]
// Constants, state encoding and functional notes for the rail sequencer
// Functional notes
// - Power-ready needs main and driver supply good; then enable starts both rails.
// - Main supply or enable low starts power-down and disables all functions.
// - Serial command interface ready within 2 ms after enable.
// - Protection latches clear only when power-ready drops, not on enable low.
// - Enable rising edge latches clock and data pins as 2-bit start-up code.
// - Soft-start ramps both references to start-up level at 3 mV/us, continuous.
// - After soft-start with outputs above threshold, power-good follows a fixed delay.
// - Telemetry line driven high once the start-up code is latched.
// - Power-ok rising starts the serial interface awaiting commands.
// - Power-ok falling stops the interface; rails return to start-up level, continuous.
// - Valid command ramps addressed rails to target, then signals transition complete.
// - Enable loss drops both power-good at once, then ramps down at soft-start rate.
// - During shutdown each rail stops switching when its sense falls below 0.2 V.
// - Start-up code clears on power-ready reset; resampled at next enable rise.
// - Power-good low while disabled and in soft-start; released per rail afterwards.
// - Power-good of a rail drops on its trips or when enable goes low.
// - A trip on one rail drops the other rail's power-good 5 us later.
// - Processor drives clock and data; device drives only the telemetry line.
// - Packet is start, three bytes each with acknowledge slot, then stop.
// - Command decoded and executed only after the stop condition.
// - Bit times: 1-5 pattern 11000b, 6-7 rail selects, 8 zero, 10 state flag, code.
// - Telemetry bits shift out on the telemetry line timed by the serial clock.
// - Telemetry content follows the telemetry function bit and rail selects.
// - Power-state-0 flag 0 gives diode emulation, 1 gives continuous conduction.
// - Without power-ok the serial clock and data inputs are ignored.
// - Voltage transitions slew at 12.5 mV/us in forced continuous conduction.
// - Interface runs only if power-ok rises after enable; else no soft-start.
package vr_seq_pkg;
	localparam int CLK_KHZ = 10000;
	localparam int STEP_UV = 6250;
	localparam int SS_SLEW_UV_PER_US = 3000;
	localparam int VID_SLEW_UV_PER_US = 12500;
	localparam int SS_STEP_CYCLES = (STEP_UV * CLK_KHZ / 1000 + SS_SLEW_UV_PER_US - 1)
		/ SS_SLEW_UV_PER_US;
	localparam int VID_STEP_CYCLES = (STEP_UV * CLK_KHZ / 1000 + VID_SLEW_UV_PER_US - 1)
		/ VID_SLEW_UV_PER_US;
	localparam int PG_DELAY_US = 100;
	localparam int PG_DELAY_CYCLES = PG_DELAY_US * CLK_KHZ / 1000;
	localparam int CROSS_TRIP_US = 5;
	localparam int CROSS_TRIP_CYCLES = CROSS_TRIP_US * CLK_KHZ / 1000;
	localparam int READY_MS = 2;
	localparam int READY_CYCLES = READY_MS * CLK_KHZ;
	localparam int LEVEL_W = 8;
	localparam logic [7:0] BOOT_LEVEL_00 = 8'hB0;
	localparam logic [7:0] BOOT_LEVEL_01 = 8'hA0;
	localparam logic [7:0] BOOT_LEVEL_10 = 8'h90;
	localparam logic [7:0] BOOT_LEVEL_11 = 8'h80;
	localparam logic [7:0] VID_TOP_LEVEL = 8'hF8;
	localparam logic [7:0] LEVEL_RESET = 8'h00;
	localparam int PKT_BITS = 27;
	localparam logic [4:0] PKT_PATTERN = 5'h18;
	localparam int BT_PATTERN_HI = 1;
	localparam int BT_SEL_CORE = 6;
	localparam int BT_SEL_NB = 7;
	localparam int BT_ZERO = 8;
	localparam int BT_PSI0 = 10;
	localparam int BT_VID_HI = 11;
	localparam int BT_VID0 = 19;
	localparam int BT_TFN = 21;
	localparam int TELEM_BITS = 20;
	typedef enum logic [4:0] {
		ST_OFF = 5'h01,
		ST_SOFTSTART = 5'h02,
		ST_PGWAIT = 5'h04,
		ST_RUN = 5'h08,
		ST_SHUTDOWN = 5'h10
	} seq_state_t;
endpackage

// [hdl/ref_ramp.sv]
// One rail reference stepping toward its target, one step per enable
`timescale 1ns/1ps
module ref_ramp #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Step control
	input wire logic stepEn,
	input wire logic [W-1:0] target,
	// Reference state
	output logic [W-1:0] level,
	output logic atTarget
);
	assign atTarget = (level == target);

	// Move one step per tick, up or down
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			level <= '0;
		end
		else if (stepEn && (level < target))
		begin
			level <= level + W'(1);
		end
		else if (stepEn && (level > target))
		begin
			level <= level - W'(1);
		end
	end
endmodule // ref_ramp

// [sim/vr_seq_chk.sv]
// Port-level assertions for the rail sequencer
`timescale 1ns/1ps
module vr_seq_chk #(
	parameter int READY_CYCLES = 20000,
	parameter int TELEM_BITS = 20
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Watched inputs and outputs
	input wire logic enableHigh,
	input wire logic powerReady,
	input wire logic sequenceFault,
	input wire logic [1:0] startupVoltageCode,
	input wire logic telemetryLine,
	input wire logic [1:0] powerGood,
	input wire logic [1:0] tripLatched,
	input wire logic [1:0] transitionDone,
	input wire logic [7:0] coreReference
);
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (reset);

	// Power-good and supply state
	a_pg_needs_ready: assert property (powerGood != 2'h0 |-> powerReady)
		else $error("power good without power ready");
	a_pg_enable_loss: assert property ($fell(enableHigh) |-> ##[1:5] powerGood == 2'h0)
		else $error("power good kept after enable loss");
	a_code_cleared: assert property (!powerReady && !$past(powerReady) |->
		startupVoltageCode == 2'h0)
		else $error("boot code kept without power ready");
	a_telem_low_off: assert property (!powerReady && !$past(powerReady) &&
		!$past(powerReady, 2) |-> !telemetryLine)
		else $error("telemetry high before code latched");
	a_fault_no_start: assert property (sequenceFault && $past(sequenceFault, 8) |->
		powerGood == 2'h0 && coreReference == 8'h00)
		else $error("start-up despite wrong sequence");
	// Protection latches and their effect on power-good
	a_trip_kept: assert property ($fell(tripLatched[0]) || $fell(tripLatched[1]) |->
		##[0:2] !powerReady)
		else $error("trip latch cleared with power ready");
	a_own_trip: assert property ($rose(tripLatched[1]) |-> ##[0:2] !powerGood[1])
		else $error("tripped rail keeps power good");
	a_cross_not_early: assert property ($rose(tripLatched[1]) && powerGood[0] |=>
		powerGood[0] [*8])
		else $error("other rail dropped too early");
	a_cross_late: assert property ($rose(tripLatched[1]) |-> ##[40:60] !powerGood[0])
		else $error("other rail not dropped after trip");
	// Transition complete is a single pulse at a settled reference
	a_done_pulse: assert property (transitionDone[0] |->
		$stable(coreReference) ##1 !transitionDone[0])
		else $error("transition done not a settled pulse");

	c_done: cover property (transitionDone[0]);
	c_fault: cover property ($rose(sequenceFault));
	c_both_good: cover property (powerGood == 2'h3);
endmodule // vr_seq_chk

bind vr_sequencer_serial_vid_slave vr_seq_chk #(
	.READY_CYCLES(READY_CYCLES),
	.TELEM_BITS(TELEM_BITS)
) vr_seq_chk_i (
	.core_clk(core_clk),
	.reset(reset),
	.enableHigh(enableHigh),
	.powerReady(powerReady),
	.sequenceFault(sequenceFault),
	.startupVoltageCode(startupVoltageCode),
	.telemetryLine(telemetryLine),
	.powerGood(powerGood),
	.tripLatched(tripLatched),
	.transitionDone(transitionDone),
	.coreReference(coreReference)
);

// [sim/serial_cmd_host.sv]
// Host-side master of the three-wire serial command link
`timescale 1ns/1ps
module serial_cmd_host #(
	parameter int HALF_NS = 400
) (
	// Clock and data toward the device
	output logic serClk,
	output logic serData
);
	logic [1:27] frame;

	// Bus idles with both lines at their pull-up level
	initial
	begin
		serClk = 1'h1;
		serData = 1'h1;
	end

	// Static pin levels, used as boot strap before enable
	task automatic set_pins(input logic c, input logic d);
		serClk <= c;
		serData <= d;
	endtask

	// Start, 27 bit times with released ack slots, stop
	task automatic send(input logic core, nb, bad, psi0, telemetry_function_bit, input logic [7:0] code);
		frame = {5'h18, core, nb, bad, 1'h1, psi0, code[7:1], 1'h1, code[0], 1'h1, telemetry_function_bit,
			5'h1F, 1'h1};
		// Move off the caller's clock edge
		#10;
		serData = 1'h0;
		#HALF_NS serClk = 1'h0;
		for (int t = 1; t <= 27; t++)
		begin
			serData = frame[t];
			#HALF_NS serClk = 1'h1;
			#HALF_NS serClk = 1'h0;
		end
		serData = 1'h0;
		#HALF_NS serClk = 1'h1;
		#HALF_NS serData = 1'h1;
		#HALF_NS;
	endtask
endmodule // serial_cmd_host

// [sim/tb_top.sv]
// Self-checking bench for the rail sequencer and serial command slave
`timescale 1ns/1ps
module tb_top;
	logic core_clk = 1'h0;
	logic reset = 1'h1;
	logic mainSupplyOk = 1'h0, driverSupplyOk = 1'h0, enableHigh = 1'h0, platformPowerOk = 1'h0;
	logic serClk, serData, powerReady, serialReady, sequenceFault, telemetryLine;
	logic [1:0] inRegulation = 2'h3, aboveOffLevel = 2'h3, overVoltageTrip = 2'h0;
	logic [1:0] overCurrentTrip = 2'h0, underVoltageTrip = 2'h0;
	logic [19:0] telemetryWord = 20'hA5C3F;
	logic [1:0] startupVoltageCode, powerGood, switchingOn, diodeEmulation, tripLatched;
	logic [1:0] transitionDone;
	logic [2:0] telemetryFunction;
	logic [7:0] coreReference, nbReference;
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;
	int n;

	// Clock
	initial
	begin
		forever #50 core_clk = ~core_clk;
	end

	vr_sequencer_serial_vid_slave #(.READY_CYCLES(200), .TELEM_BITS(20))
	vr_sequencer_serial_vid_slave_i (.core_clk(core_clk), .reset(reset),
		.mainSupplyOk(mainSupplyOk), .driverSupplyOk(driverSupplyOk), .enableHigh(enableHigh),
		.platformPowerOk(platformPowerOk), .serialVidClock(serClk), .serialVidData(serData),
		.inRegulation(inRegulation), .aboveOffLevel(aboveOffLevel),
		.overVoltageTrip(overVoltageTrip), .overCurrentTrip(overCurrentTrip),
		.underVoltageTrip(underVoltageTrip), .telemetryWord(telemetryWord),
		.powerReady(powerReady), .serialReady(serialReady), .sequenceFault(sequenceFault),
		.startupVoltageCode(startupVoltageCode), .telemetryLine(telemetryLine),
		.telemetryFunction(telemetryFunction), .powerGood(powerGood), .switchingOn(switchingOn),
		.diodeEmulation(diodeEmulation), .tripLatched(tripLatched),
		.transitionDone(transitionDone), .coreReference(coreReference), .nbReference(nbReference));

	serial_cmd_host serial_cmd_host_i (.serClk(serClk), .serData(serData));

	// Hang guard
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			mismatches++;
			print_verdict;
		end
	end

	// Compare one result
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
	endtask

	task automatic print_verdict;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		tick(4);
		reset <= 1'h0;
		tick(2);
		chk(telemetryLine, 8'h00, "telemetry before code");
		mainSupplyOk <= 1'h1;
		driverSupplyOk <= 1'h1;
		tick(6);
		chk(powerReady, 8'h01, "power ready");
		// Every boot code latched at enable rise, cleared on power loss
		for (int c = 3; c >= 0; c--)
		begin
			serial_cmd_host_i.set_pins(c[1], c[0]);
			enableHigh <= 1'h1;
			tick(8);
			chk(startupVoltageCode, 8'(c), "boot code");
			chk(telemetryLine, 8'h01, "telemetry after code");
			enableHigh <= 1'h0;
			mainSupplyOk <= 1'h0;
			tick(8);
			chk(powerReady, 8'h00, "power lost");
			chk(startupVoltageCode, 8'h00, "code cleared");
			mainSupplyOk <= 1'h1;
			tick(6);
		end
		// Soft-start to the 01 boot level
		serial_cmd_host_i.set_pins(1'h0, 1'h1);
		enableHigh <= 1'h1;
		tick(100);
		chk(powerGood, 8'h00, "pg in soft-start");
		serial_cmd_host_i.set_pins(1'h1, 1'h1);
		for (n = 0; n < 6000 && powerGood !== 2'h3; n++) tick(1);
		chk(powerGood, 8'h03, "pg after start");
		chk(coreReference, vr_seq_pkg::BOOT_LEVEL_01, "core boot level");
		chk(nbReference, vr_seq_pkg::BOOT_LEVEL_01, "nb boot level");
		// Commands once power-ok follows enable
		platformPowerOk <= 1'h1;
		tick(10);
		chk(serialReady, 8'h01, "link ready");
		fork
			serial_cmd_host_i.send(1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 8'h78);
			begin
				tick(20);
				chk(telemetryLine, 8'(telemetryWord[18]), "telemetry bit 2");
			end
		join
		for (n = 0; n < 400 && transitionDone[0] !== 1'h1; n++) tick(1);
		chk(transitionDone, 8'h01, "core done");
		chk(coreReference, 8'h80, "core target");
		chk(nbReference, vr_seq_pkg::BOOT_LEVEL_01, "nb untouched");
		chk(telemetryFunction, 8'h05, "telemetry select");
		tick(2);
		chk(diodeEmulation, 8'h01, "psi0 low");
		serial_cmd_host_i.send(1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 8'h48);
		tick(300);
		chk(nbReference, vr_seq_pkg::BOOT_LEVEL_01, "malformed dropped");
		serial_cmd_host_i.send(1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 8'h48);
		for (n = 0; n < 400 && transitionDone[1] !== 1'h1; n++) tick(1);
		chk(nbReference, 8'hB0, "nb target");
		chk(powerGood, 8'h03, "pg through move");
		// Power-ok loss: back to boot level, link ignored
		platformPowerOk <= 1'h0;
		tick(400);
		chk(coreReference, vr_seq_pkg::BOOT_LEVEL_01, "core back to boot");
		chk(nbReference, vr_seq_pkg::BOOT_LEVEL_01, "nb back to boot");
		chk(diodeEmulation, 8'h00, "continuous again");
		serial_cmd_host_i.send(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 8'h78);
		tick(300);
		chk(coreReference, vr_seq_pkg::BOOT_LEVEL_01, "link ignored");
		// Trip on the northbridge rail, then enable loss and shutdown
		overVoltageTrip <= 2'h2;
		tick(3);
		overVoltageTrip <= 2'h0;
		tick(10);
		chk(tripLatched, 8'h02, "trip latched");
		chk(powerGood, 8'h01, "other rail still good");
		tick(60);
		chk(powerGood, 8'h00, "other rail dropped");
		enableHigh <= 1'h0;
		tick(20);
		chk(tripLatched, 8'h02, "latch kept");
		aboveOffLevel <= 2'h2;
		tick(10);
		chk(switchingOn, 8'h02, "core stopped");
		aboveOffLevel <= 2'h0;
		for (n = 0; n < 5000 && (coreReference | nbReference) !== 8'h00; n++) tick(1);
		chk(coreReference | nbReference, 8'h00, "ramped down");
		chk(switchingOn, 8'h00, "both stopped");
		mainSupplyOk <= 1'h0;
		tick(8);
		chk(tripLatched, 8'h00, "latch cleared");
		// Power-ok before enable: no start-up
		mainSupplyOk <= 1'h1;
		aboveOffLevel <= 2'h3;
		platformPowerOk <= 1'h1;
		tick(8);
		enableHigh <= 1'h1;
		tick(300);
		chk(sequenceFault, 8'h01, "wrong order flagged");
		chk(coreReference, 8'h00, "no soft-start");
		print_verdict;
	end
endmodule // tb_top
